// >>> verilog/pbsp_pkg.sv
package pbsp_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 17;
  localparam int DATA_W = 36;
  localparam int LANES  = 4;
  localparam int LANE_W = 9;
  localparam int DEPTH  = 131072;
  localparam int BEAT_W = 2;

  localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_ONE   = 2'h1;
  localparam logic [BEAT_W-1:0] BEAT_LAST  = 2'h3;
  localparam logic [LANES-1:0]  LANES_ALL  = 4'hF;
  localparam logic [LANES-1:0]  LANES_NONE = 4'h0;

  // ----------------------------------------------------------------
  // static pin levels
  // ----------------------------------------------------------------
  localparam logic ORDER_XOR     = 1'h1;
  localparam logic SEL_MASTER_ON = 1'h0;
  localparam logic SEL_HIGH_ON   = 1'h1;
  localparam logic SEL_LOW_ON    = 1'h0;

  typedef enum logic {
    HOST_IDLE = 1'b0,
    HOST_BEAT = 1'b1
  } pbsp_hstate_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [BEAT_W-1:0] startLow;
    logic [BEAT_W-1:0] beat;
    logic              active;
    logic              rdAcc;
    logic              outVld;
    logic [DATA_W-1:0] outData;
  } pbsp_dev_state_t;

  localparam pbsp_dev_state_t DEV_RESET = '0;

  typedef struct packed {
    pbsp_hstate_t      st;
    logic [BEAT_W-1:0] beatsLeft;
    logic [ADDR_W-1:0] addr;
    logic              procN;
    logic              ctrlN;
    logic              stepN;
    logic              fullN;
    logic              gateN;
    logic [LANES-1:0]  lanesN;
    logic              oeN;
    logic [DATA_W-1:0] dq;
    logic              dqOe;
    logic              pinRead;
    logic              tag1;
    logic              tag2;
    logic              rspValid;
    logic [DATA_W-1:0] rspData;
  } pbsp_host_state_t;

  localparam pbsp_host_state_t HOST_RESET = '{
    st: HOST_IDLE, beatsLeft: '0, addr: '0, procN: 1'b1, ctrlN: 1'b1,
    stepN: 1'b1, fullN: 1'b1, gateN: 1'b1, lanesN: 4'hF, oeN: 1'b1,
    dq: '0, dqOe: 1'b0, pinRead: 1'b0, tag1: 1'b0, tag2: 1'b0,
    rspValid: 1'b0, rspData: '0};

  // full-word write wins over the byte lanes
  function automatic logic [LANES-1:0] pbsp_lane_mask(
    input logic             fullN,
    input logic             gateN,
    input logic [LANES-1:0] lanesN
  );
    if (!fullN) begin
      return LANES_ALL;
    end
    if (!gateN) begin
      return ~lanesN;
    end
    return LANES_NONE;
  endfunction

endpackage

// >>> verilog/pbsp_if.sv
`timescale 1ns/100ps
interface pbsp_if;
  import pbsp_pkg::*;

  logic [ADDR_W-1:0] wordAddressBus;
  logic              masterSelectN;
  logic              selectHigh;
  logic              selectLowN;
  logic              processorStrobeN;
  logic              controllerStrobeN;
  logic              burstStepN;
  logic              fullWordWriteN;
  logic              byteWriteGateN;
  logic [LANES-1:0]  laneWriteN;
  logic              outputEnableN;
  logic              burstOrderSel;
  logic              flowThroughN;
  logic              sleepReq;
  logic [DATA_W-1:0] hostDq;
  logic              hostDqOe;
  logic [DATA_W-1:0] devDq;
  logic              devDqOe;
  logic [DATA_W-1:0] dqBus;

  // ----------------------------------------------------------------
  // shared data wire
  // ----------------------------------------------------------------
  // floating bus reads as zero here
  assign dqBus = devDqOe ? devDq : (hostDqOe ? hostDq : '0);

  modport device (
    input  wordAddressBus, masterSelectN, selectHigh, selectLowN,
    input  processorStrobeN, controllerStrobeN, burstStepN,
    input  fullWordWriteN, byteWriteGateN, laneWriteN, outputEnableN,
    input  burstOrderSel, flowThroughN, sleepReq, dqBus,
    output devDq, devDqOe
  );

  modport host (
    output wordAddressBus, masterSelectN, selectHigh, selectLowN,
    output processorStrobeN, controllerStrobeN, burstStepN,
    output fullWordWriteN, byteWriteGateN, laneWriteN, outputEnableN,
    output burstOrderSel, flowThroughN, sleepReq, hostDq, hostDqOe,
    input  dqBus
  );
endinterface

// >>> verilog/pbsp_burst_step.sv
`timescale 1ns/100ps
module pbsp_burst_step
  import pbsp_pkg::*;
(
  input  wire logic [BEAT_W-1:0] curLow,
  input  wire logic [BEAT_W-1:0] startLow,
  input  wire logic [BEAT_W-1:0] beat,
  input  wire logic              orderXor,
  output logic      [BEAT_W-1:0] nxtLow,
  output logic      [BEAT_W-1:0] nxtBeat
);

  // ----------------------------------------------------------------
  // next low address bits
  // ----------------------------------------------------------------
  // beat count wraps at four, so a long burst repeats its group
  assign nxtBeat = beat + BEAT_ONE;
  assign nxtLow  = orderXor ? (startLow ^ nxtBeat) : (curLow + BEAT_ONE);  // see [R16]

endmodule

// >>> verilog/pbsp_device.sv
`timescale 1ns/100ps
// Behaviour
// [R01] inputs sampled on rising edge; four static/async
// [R02] address loads with enables active and strobe
// [R03] data lines driven only when enabled, reading
// [R04] master select gates processor strobe only
// [R05] second select high, third select low
// [R06] processor strobe loads address or deselects
// [R07] controller strobe independently starts or deselects
// [R08] step low continues burst to next address
// [R09] full-word write stores all lanes
// [R10] lane controls need gate low, full high
// [R11] no lane active means read cycle
// [R12] output enable acts without clock
// [R13] order pin high xor, low linear
// [R14] flow-through pin low bypasses output register
// [R15] sleep holds contents, drops activity
// [R16] low two bits follow chosen order
// [R17] pipelined read appears after next edge
// [R18] step only with both strobes idle
// [R19] upper bits fixed, wrap in group
module pbsp_device
  import pbsp_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  pbsp_if.device    bus
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  pbsp_dev_state_t   devState_ff;
  pbsp_dev_state_t   nxt_devState;
  logic [DATA_W-1:0] mem [0:DEPTH-1];
  logic [DATA_W-1:0] rdWord;
  logic [DATA_W-1:0] oldWord;
  logic [DATA_W-1:0] wrWord;
  logic [ADDR_W-1:0] wrAddr;
  logic [ADDR_W-1:0] accAddr;
  logic [LANES-1:0]  laneMask;
  logic [BEAT_W-1:0] stepLow;
  logic [BEAT_W-1:0] stepBeat;
  logic              selected;
  logic              procStart;
  logic              ctrlStart;
  logic              isWrite;
  logic              wrEn;
  logic              flowMode;
  logic              orderXor;
  logic              stepReq;
  logic              readLive;
  logic [DATA_W-1:0] showWord;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // the master select enters both the full select and the processor strobe
  function automatic logic masterOn(input logic masterSelN);
    return (masterSelN == SEL_MASTER_ON);
  endfunction

  // ----------------------------------------------------------------
  // pin decode
  // ----------------------------------------------------------------
  // decode here is evaluated at the edge, except isWrite, which also gates the data drivers live; static pins are
  // read live and may change at any time
  // all three selects must stand at their active levels on one edge
  assign selected  = masterOn(bus.masterSelectN)
                   & (bus.selectHigh == SEL_HIGH_ON)
                   & (bus.selectLowN == SEL_LOW_ON);               // see [R05]

  // processor strobe is blocked by the master select
  assign procStart = ~bus.processorStrobeN
                   & masterOn(bus.masterSelectN);                  // see [R04]

  // controller strobe counts only while the processor strobe is idle
  assign ctrlStart = ~bus.controllerStrobeN & ~procStart;          // see [R07]

  // full-word write outranks the byte gate and its lanes
  assign laneMask  = pbsp_lane_mask(bus.fullWordWriteN,
                                    bus.byteWriteGateN,
                                    bus.laneWriteN);               // see [R09] [R10]

  // gate low with every lane idle is a plain read, not a write
  assign isWrite   = |laneMask;                                    // see [R11]
  // static pins are meant to be tied off, so they are not registered
  assign flowMode  = ~bus.flowThroughN;                            // see [R14]
  assign orderXor  = (bus.burstOrderSel == ORDER_XOR);             // see [R13]

  // advance is ignored whenever either strobe is taken this edge
  assign stepReq   = ~bus.burstStepN & ~procStart & ~ctrlStart;   // see [R18]

  // ----------------------------------------------------------------
  // burst address
  // ----------------------------------------------------------------
  // beat 0 is the loaded word; stepping starts on the edge after the load
  pbsp_burst_step u_burstStep (
    .curLow   (devState_ff.addr[BEAT_W-1:0]),
    .startLow (devState_ff.startLow),
    .beat     (devState_ff.beat),
    .orderXor (orderXor),
    .nxtLow   (stepLow),
    .nxtBeat  (stepBeat)
  );

  // upper bits never carry out of the four-word group
  assign accAddr = stepReq
                 ? {devState_ff.addr[ADDR_W-1:BEAT_W], stepLow}
                 : devState_ff.addr;                               // see [R08] [R19]

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // the array has no reset, so words never written read as unknown
  assign rdWord  = mem[devState_ff.addr];
  // byte writes merge with the old word within the same edge
  assign oldWord = mem[wrAddr];

  // one merge slice per byte lane
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : gLane
      // unwritten lanes keep their stored bits
      assign wrWord[g*LANE_W +: LANE_W] = laneMask[g]
                                        ? bus.dqBus[g*LANE_W +: LANE_W]
                                        : oldWord[g*LANE_W +: LANE_W];
    end
  endgenerate

  // no reset on the array: contents are never cleared by hardware
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrWord;                                       // see [R01]
    end
  end

  // ----------------------------------------------------------------
  // cycle control
  // ----------------------------------------------------------------
  always_comb begin
    nxt_devState = devState_ff;
    wrEn         = 1'b0;
    wrAddr       = devState_ff.addr;
    // sleep freezes everything, so a wake resumes where it stopped
    if (!bus.sleepReq) begin                                       // see [R15]
      // word read at the registered address moves to the output stage
      if (devState_ff.rdAcc) begin
        nxt_devState.outData = rdWord;                             // see [R17]
      end
      // the output stage is valid one edge after each array read
      nxt_devState.outVld = devState_ff.rdAcc;
      if (procStart || ctrlStart) begin
        if (selected) begin                                        // see [R02]
          nxt_devState.addr     = bus.wordAddressBus;
          nxt_devState.startLow = bus.wordAddressBus[BEAT_W-1:0];
          nxt_devState.beat     = BEAT_FIRST;
          nxt_devState.active   = 1'b1;
          // lanes are ignored on the processor strobe edge: always a read
          nxt_devState.rdAcc    = procStart | ~isWrite;            // see [R06]
          wrEn                  = ctrlStart & isWrite;             // see [R07]
          wrAddr                = bus.wordAddressBus;
        end else begin
          // deselect ends the burst; a word already staged still leaves
          nxt_devState.active = 1'b0;                              // see [R06]
          nxt_devState.rdAcc  = 1'b0;
        end
      end else if (devState_ff.active) begin
        // no strobe: continue or suspend the running access
        if (stepReq) begin
          nxt_devState.addr = accAddr;                             // see [R18]
          nxt_devState.beat = stepBeat;
        end
        // a write inside a burst lands at the stepped address
        wrEn               = isWrite;
        wrAddr             = accAddr;
        nxt_devState.rdAcc = ~isWrite;
      end else begin
        // deselected and idle: nothing is read until the next start
        nxt_devState.rdAcc = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      // reset clears status only; the array keeps its contents
      devState_ff <= DEV_RESET;
    end else begin
      devState_ff <= nxt_devState;                                 // see [R01]
    end
  end

  // ----------------------------------------------------------------
  // data drive
  // ----------------------------------------------------------------
  // flow-through shows the array word one edge earlier than pipelined
  assign readLive = flowMode ? devState_ff.rdAcc : devState_ff.outVld;  // see [R14] [R17]

  // bypassing the output register trades clock-to-data time for one edge of latency
  assign showWord  = flowMode ? rdWord : devState_ff.outData;
  assign bus.devDq = readLive ? showWord : '0;

  // output enable is purely combinational; a write command on the pins
  // also drops the drivers at once so the master can own the bus
  assign bus.devDqOe = readLive
                     & ~bus.outputEnableN
                     & ~bus.sleepReq
                     & ~isWrite;                                   // see [R03] [R12]

endmodule

// >>> verilog/pbsp_host.sv
`timescale 1ns/100ps
module pbsp_host
  import pbsp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  pbsp_if.host                   bus,
  input  wire logic              reqValid,
  output logic                   reqReady,
  input  wire logic              reqWrite,
  input  wire logic              reqBurst,
  input  wire logic              reqUseCtrl,
  input  wire logic [ADDR_W-1:0] reqAddr,
  input  wire logic [DATA_W-1:0] reqData,
  input  wire logic [LANES-1:0]  reqLanes,
  input  wire logic              orderXor,
  input  wire logic              flowMode,
  input  wire logic              sleepMode,
  output logic                   rspValid,
  output logic      [DATA_W-1:0] rspData
);

  pbsp_host_state_t host_ff;
  pbsp_host_state_t nxt_host;
  logic             takeRsp;

  // ----------------------------------------------------------------
  // request sequencing
  // ----------------------------------------------------------------
  // reads in flight block new requests so the bus never has two drivers
  assign reqReady = (host_ff.st == HOST_IDLE) & ~host_ff.pinRead
                  & ~host_ff.tag1 & ~host_ff.tag2 & ~sleepMode;
  assign takeRsp  = flowMode ? host_ff.tag1 : host_ff.tag2;        // see [R14] [R17]

  always_comb begin
    nxt_host          = host_ff;
    nxt_host.procN    = 1'b1;
    nxt_host.ctrlN    = 1'b1;
    nxt_host.stepN    = 1'b1;
    nxt_host.fullN    = 1'b1;
    nxt_host.gateN    = 1'b1;
    nxt_host.lanesN   = LANES_ALL;
    nxt_host.oeN      = 1'b0;
    nxt_host.dqOe     = 1'b0;
    nxt_host.pinRead  = 1'b0;
    nxt_host.tag1     = host_ff.pinRead;
    nxt_host.tag2     = host_ff.tag1;
    nxt_host.rspValid = takeRsp;
    if (takeRsp) begin
      nxt_host.rspData = bus.dqBus;
    end
    case (host_ff.st)
      HOST_IDLE: begin
        if (reqValid && reqReady) begin
          nxt_host.addr = reqAddr;
          if (reqWrite) begin
            // writes go on the controller strobe; the other ignores lanes
            nxt_host.ctrlN  = 1'b0;                                // see [R07]
            nxt_host.fullN  = (reqLanes != LANES_ALL);             // see [R09]
            nxt_host.gateN  = (reqLanes == LANES_ALL);             // see [R10]
            nxt_host.lanesN = ~reqLanes;
            nxt_host.oeN    = 1'b1;
            nxt_host.dq     = reqData;
            nxt_host.dqOe   = 1'b1;
          end else begin
            nxt_host.procN   = reqUseCtrl;                         // see [R06]
            nxt_host.ctrlN   = ~reqUseCtrl;
            nxt_host.pinRead = 1'b1;
            if (reqBurst) begin
              nxt_host.st        = HOST_BEAT;
              nxt_host.beatsLeft = BEAT_LAST;
            end
          end
        end
      end
      HOST_BEAT: begin
        nxt_host.stepN     = 1'b0;                                 // see [R08]
        nxt_host.pinRead   = 1'b1;
        nxt_host.beatsLeft = host_ff.beatsLeft - BEAT_ONE;
        if (host_ff.beatsLeft == BEAT_ONE) begin
          nxt_host.st = HOST_IDLE;
        end
      end
      default: begin
        nxt_host.st = HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      host_ff <= HOST_RESET;
    end else begin
      host_ff <= nxt_host;                                         // see [R01]
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign bus.wordAddressBus    = host_ff.addr;
  assign bus.masterSelectN     = SEL_MASTER_ON;
  assign bus.selectHigh        = SEL_HIGH_ON;
  assign bus.selectLowN        = SEL_LOW_ON;
  assign bus.processorStrobeN  = host_ff.procN;
  assign bus.controllerStrobeN = host_ff.ctrlN;
  assign bus.burstStepN        = host_ff.stepN;
  assign bus.fullWordWriteN    = host_ff.fullN;
  assign bus.byteWriteGateN    = host_ff.gateN;
  assign bus.laneWriteN        = host_ff.lanesN;
  assign bus.outputEnableN     = host_ff.oeN;
  assign bus.burstOrderSel     = orderXor;                         // see [R13]
  assign bus.flowThroughN      = ~flowMode;                        // see [R14]
  assign bus.sleepReq          = sleepMode;                        // see [R15]
  assign bus.hostDq            = host_ff.dq;
  assign bus.hostDqOe          = host_ff.dqOe;
  assign rspValid              = host_ff.rspValid;
  assign rspData               = host_ff.rspData;

endmodule

// >>> verif/pbsp_chk.sv
`timescale 1ns/100ps
module pbsp_chk
  import pbsp_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              masterSelectN,
  input wire logic              selectHigh,
  input wire logic              selectLowN,
  input wire logic              processorStrobeN,
  input wire logic              controllerStrobeN,
  input wire logic              burstStepN,
  input wire logic              fullWordWriteN,
  input wire logic              byteWriteGateN,
  input wire logic [LANES-1:0]  laneWriteN,
  input wire logic              outputEnableN,
  input wire logic              flowThroughN,
  input wire logic              sleepReq,
  input wire logic              hostDqOe,
  input wire logic [DATA_W-1:0] devDq,
  input wire logic              devDqOe
);
  logic writePins;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // pin relations
  // ----------------------------------------------------------------
  // a write on the pins must silence the device even with oe low
  assign writePins = !fullWordWriteN || (!byteWriteGateN && laneWriteN != LANES_ALL);

  sequence procRead;
    !processorStrobeN && !masterSelectN && selectHigh && !selectLowN && !sleepReq;
  endsequence

  sequence readShown;
    devDqOe || outputEnableN || sleepReq || writePins;
  endsequence

  a_drive_needs_oe: assert property (devDqOe |-> !outputEnableN && !sleepReq)
    else $error("device drives data without output enable");
  a_write_quiet: assert property (writePins |-> !devDqOe)
    else $error("device drives data in a write cycle");
  a_write_by_ctrl: assert property (writePins |->
    !controllerStrobeN && hostDqOe)
    else $error("write lanes without controller strobe or data");
  a_oe_before_drive: assert property (hostDqOe |-> outputEnableN && !devDqOe)
    else $error("host drives data while output enable is low");
  a_pipe_latency: assert property (procRead ##0 flowThroughN |-> ##2 readShown)
    else $error("pipelined read data not shown two edges later");
  a_flow_latency: assert property (procRead ##0 !flowThroughN |-> ##1 readShown)
    else $error("flow-through read data not shown one edge later");
  a_sleep_hold: assert property (sleepReq |=> $stable(devDq))
    else $error("device output changed during sleep");
  a_selects_on: assert property (!masterSelectN && selectHigh && !selectLowN)
    else $error("chip selects not at their active levels");
  a_burst_steps: assert property (!processorStrobeN ##1 !burstStepN |->
    !burstStepN [*3] ##1 burstStepN)
    else $error("burst step not held for three beats");
  a_strobe_no_step: assert property (!processorStrobeN |-> burstStepN)
    else $error("burst step asserted on a strobe edge");
endmodule

// >>> verif/test_pipelined_burst_sram_port.sv
`timescale 1ns/100ps
module test_pipelined_burst_sram_port;
  import pbsp_pkg::*;

  logic              clk;
  logic              reset;
  logic              reqValid;
  logic              reqReady;
  logic              reqWrite;
  logic              reqBurst;
  logic              reqUseCtrl;
  logic [ADDR_W-1:0] reqAddr;
  logic [DATA_W-1:0] reqData;
  logic [LANES-1:0]  reqLanes;
  logic              orderXor;
  logic              flowMode;
  logic              sleepMode;
  logic              rspValid;
  logic [DATA_W-1:0] rspData;
  int                mismatches;
  int                check_count;
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] rspQ [$];
  logic [ADDR_W-1:0] base;

  pbsp_if bus_if ();
  pbsp_device pbsp_device_i (.clk(clk), .reset(reset), .bus(bus_if));
  pbsp_host pbsp_host_i (.clk(clk), .reset(reset), .bus(bus_if), .reqValid(reqValid),
    .reqReady(reqReady), .reqWrite(reqWrite), .reqBurst(reqBurst), .reqUseCtrl(reqUseCtrl),
    .reqAddr(reqAddr), .reqData(reqData), .reqLanes(reqLanes), .orderXor(orderXor),
    .flowMode(flowMode), .sleepMode(sleepMode), .rspValid(rspValid), .rspData(rspData));
  pbsp_chk pbsp_chk_i (.clk(clk), .reset(reset), .masterSelectN(bus_if.masterSelectN),
    .selectHigh(bus_if.selectHigh), .selectLowN(bus_if.selectLowN),
    .processorStrobeN(bus_if.processorStrobeN), .controllerStrobeN(bus_if.controllerStrobeN),
    .burstStepN(bus_if.burstStepN), .fullWordWriteN(bus_if.fullWordWriteN),
    .byteWriteGateN(bus_if.byteWriteGateN), .laneWriteN(bus_if.laneWriteN),
    .outputEnableN(bus_if.outputEnableN), .flowThroughN(bus_if.flowThroughN),
    .sleepReq(bus_if.sleepReq), .hostDqOe(bus_if.hostDqOe), .devDq(bus_if.devDq),
    .devDqOe(bus_if.devDqOe));

  always #50 clk = ~clk;

  // sampled mid-cycle, away from the edge that launches the response
  always @(negedge clk) begin
    if (rspValid === 1'b1) begin
      rspQ.push_back(rspData);
    end
  end

  // ----------------------------------------------------------------
  // expectations and checks
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] nw, input logic [LANES-1:0] ln);
    logic [DATA_W-1:0] r;
    r = old;
    for (int g = 0; g < LANES; g++) begin
      if (ln[g]) begin
        r[g*LANE_W +: LANE_W] = nw[g*LANE_W +: LANE_W];
      end
    end
    return r;
  endfunction

  function automatic logic [ADDR_W-1:0] beatAddr(input logic [ADDR_W-1:0] a, input int b,
    input logic ox);
    logic [BEAT_W-1:0] lo;
    lo = ox ? (a[1:0] ^ BEAT_W'(b)) : (a[1:0] + BEAT_W'(b));
    return {a[ADDR_W-1:2], lo};
  endfunction

  task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // holds the request until the edge that finds ready high
  task automatic send(input logic wr, input logic bu, input logic uc,
    input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [LANES-1:0] ln);
    logic rdy;
    @(negedge clk);
    reqValid = 1'b1;
    reqWrite = wr;
    reqBurst = bu;
    reqUseCtrl = uc;
    reqAddr = a;
    reqData = d;
    reqLanes = ln;
    for (int i = 0; i < 60; i++) begin
      rdy = reqReady;
      @(posedge clk);
      if (rdy === 1'b1) break;
      @(negedge clk);
    end
    if (rdy !== 1'b1) mismatches++;
    @(negedge clk);
    reqValid = 1'b0;
  endtask

  task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    input logic [LANES-1:0] ln);
    send(1'b1, 1'b0, 1'b1, a, d, ln);
    mem[a] = merge(mem[a], d, ln);
  endtask

  task automatic read(input logic [ADDR_W-1:0] a, input logic bu, input logic uc);
    int n;
    n = bu ? 4 : 1;
    rspQ.delete();
    send(1'b0, bu, uc, a, '0, LANES_NONE);
    check_flag(bus_if.burstOrderSel, orderXor);
    check_flag(bus_if.flowThroughN, !flowMode);
    for (int i = 0; i < 40 && rspQ.size() < n; i++) @(posedge clk);
    check_flag(rspQ.size() == n, 1'b1);
    for (int b = 0; b < n && b < rspQ.size(); b++) begin
      check_word(rspQ[b], mem[beatAddr(a, b, orderXor)]);
    end
  endtask

  task automatic summarize;
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (8000) @(posedge clk);
    mismatches++;
    summarize();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqBurst = 1'b0;
    reqUseCtrl = 1'b0;
    reqAddr = '0;
    reqData = '0;
    reqLanes = LANES_NONE;
    orderXor = ORDER_XOR;
    flowMode = 1'b0;
    sleepMode = 1'b0;
    mismatches = 0;
    check_count = 0;
    void'($urandom(32'h4E990798));
    repeat (20) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    for (int g = 0; g < 2; g++) begin
      // top group checks that the wrap never carries into upper bits
      base = g ? 17'h1FFFC : ADDR_W'($urandom()) & 17'h1FFFC;
      for (int i = 0; i < 4; i++) begin
        write(base + i, {$urandom(), 4'($urandom())}, LANES_ALL);
      end
      for (int i = 0; i < 4; i++) begin
        write(base + i, {$urandom(), 4'($urandom())},
          i ? 4'($urandom()) : LANES_NONE);
      end
      for (int m = 0; m < 4; m++) begin
        @(negedge clk);
        orderXor = m[1];
        flowMode = m[0];
        for (int s = 0; s < 4; s++) read(base + s, 1'b1, s == 3);
        read(base + m, 1'b0, m[0]);
      end
      for (int i = 0; i < 12; i++) begin
        if ($urandom() % 2) begin
          write(base + $urandom() % 4, {$urandom(), 4'($urandom())}, 4'($urandom()));
        end else begin
          read(base + $urandom() % 4, 1'($urandom()), 1'($urandom()));
        end
      end
      @(negedge clk);
      sleepMode = 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check_flag(reqReady, 1'b0);
      check_flag(bus_if.devDqOe, 1'b0);
      @(negedge clk);
      sleepMode = 1'b0;
      read(base, 1'b1, 1'b0);
    end
    summarize();
  end
endmodule
